// File: src/pibs_io_bus_select.sv
// Processor side of the shared I/O bus: select strobes, bus drive, control
// lines, interrupt lines and the firmware bus test.
// Assumes peripherals couple on through tri-state buffers gated by our strobes;
// all pin inputs are asynchronous and are synchronised here.
// Strobe timing is counted in clock cycles, not in bus settling time.
// How it works
// - Peripherals reach the bus only through buffers gated by our 16+16 strobes.
// - High-priority interrupt goes low when the filter transfer request is asserted.
// - Low-priority interrupt pulses per time record and follows knob pulses.
// - Output strobe 0 clocks trigger programming data.
// - Test numbers are octal; lines 8 and up use number two higher.
// - Bus test strobes one chosen line; output-line tests drive repeatable bus patterns.
// - Reset ends the bus test; re-entry needs self-test mode and jumper again.
// - Jumper shorted outside self-test mode starts the primitive ROM test.
// - Input strobe 15 enables filter data onto the bus.
// - Output strobe 14 latches filter programming data.
// - Input strobes 0 to 4 enable front panel switch registers.
// - Control line one and control line two are driven out.
// - Output strobe 13 latches oscillator frequency data.
// - Input strobe 6 reads, output strobe 6 writes the instrument bus.
// - Input strobe 13 enables overload status.
// - Input strobes 8, 11, 12 read phase, phase count, marker count.
// - Output strobe 12 latches graphics line count.
// - Output strobe 11 latches calibration and noise programming.
//
// Local design decisions: the address-and-strobe port and the register offsets.
`default_nettype none
module pibs_io_bus_select #(
  parameter int unsigned STROBE_LEN = pibs_pkg::STROBE_CYCLES,
  parameter int unsigned TEST_PERIOD = pibs_pkg::TEST_PERIOD_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [pibs_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [pibs_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [pibs_pkg::DATA_W-1:0] reg_rdata_out,
  output logic [pibs_pkg::LINES-1:0] output_select_strobe_n_out,
  output logic [pibs_pkg::LINES-1:0] input_select_strobe_n_out,
  input wire logic [pibs_pkg::DATA_W-1:0] io_bus_in,
  output logic [pibs_pkg::DATA_W-1:0] io_bus_out,
  output logic io_bus_oe_out,
  output logic control_line_one_out,
  output logic control_line_two_out,
  input wire logic filter_interrupt_request_n_in,
  input wire logic knob_interrupt_request_n_in,
  input wire logic filter_transfer_request_n_in,
  input wire logic instrument_bus_flag_n_in,
  input wire logic instrument_bus_state_line_n_in,
  input wire logic test_jumper_shorted_in,
  input wire logic self_test_mode_in,
  output logic high_prio_interrupt_n_out,
  output logic low_prio_interrupt_n_out,
  output logic rom_self_test_start_out
);

  typedef struct packed {
    pibs_pkg::pibs_state_t st;
    logic [3:0] sel;
    logic [15:0] dout;
    logic [15:0] din;
    logic ctl_one;
    logic ctl_two;
    logic test_run;
    logic [5:0] tnum;
    logic [7:0] cnt;
    logic [15:0] pat;
    logic armed;
    logic rom_test;
    logic [15:0] rdata;
    logic [6:0] sy1;
    logic [6:0] sy2;
    logic [6:0] sy3;
    logic [15:0] bus1;
    logic [15:0] bus2;
    logic [15:0] os_n;
    logic [15:0] is_n;
    logic [15:0] bus_drv;
    logic bus_oe;
    logic line_one;
    logic line_two;
    logic iph_n;
    logic ipl_n;
    logic [7:0] ipl_cnt;
  } pibs_regs_t;

  localparam logic [7:0] STROBE_LAST = 8'(STROBE_LEN - 1);
  localparam logic [7:0] STROBE_LEN_C = 8'(STROBE_LEN);
  localparam logic [7:0] PERIOD_LAST = 8'(TEST_PERIOD - 1);

  pibs_regs_t q_r;
  pibs_regs_t q_nxt;

  // Maps a printed octal test number to a select line; digits 8 and 9 are not tests
  function automatic logic [4:0] pibs_test_line(input logic [4:0] num);
    logic [4:0] line;
    line = 5'h10;
    if (num < pibs_pkg::TNUM_FIRST_GAP) begin
      line = num;
    end else if (num >= pibs_pkg::TNUM_HIGH_FIRST && num <= pibs_pkg::TNUM_LAST) begin
      line = num - pibs_pkg::TNUM_OCTAL_SKIP;
    end
    return line;
  endfunction

  logic [6:0] raw_pins;
  logic [6:0] act;
  logic [4:0] test_line;
  logic test_active;
  logic xfer_edge;
  logic knob_edge;
  logic jumper_edge;

  assign raw_pins = {self_test_mode_in, test_jumper_shorted_in,
                     instrument_bus_state_line_n_in, instrument_bus_flag_n_in,
                     filter_transfer_request_n_in, knob_interrupt_request_n_in,
                     filter_interrupt_request_n_in};

  always_comb begin
    q_nxt = q_r;
    // Active-high views, taken only from the second synchroniser stage
    act = q_r.sy2;
    act[pibs_pkg::SY_IRH] = ~q_r.sy2[pibs_pkg::SY_IRH];
    act[pibs_pkg::SY_IRL] = ~q_r.sy2[pibs_pkg::SY_IRL];
    act[pibs_pkg::SY_XFER] = ~q_r.sy2[pibs_pkg::SY_XFER];
    act[pibs_pkg::SY_FLAG] = ~q_r.sy2[pibs_pkg::SY_FLAG];
    act[pibs_pkg::SY_STATE] = ~q_r.sy2[pibs_pkg::SY_STATE];
    xfer_edge = ~q_r.sy2[pibs_pkg::SY_XFER] & q_r.sy3[pibs_pkg::SY_XFER];
    knob_edge = ~q_r.sy2[pibs_pkg::SY_IRL] & q_r.sy3[pibs_pkg::SY_IRL];
    jumper_edge = q_r.sy2[pibs_pkg::SY_JUMPER] & ~q_r.sy3[pibs_pkg::SY_JUMPER];
    test_line = pibs_test_line(q_r.tnum[4:0]);
    test_active = q_r.armed & q_r.test_run;

    // Stages reset high: a jumper held through reset gives no edge, so no re-arm
    q_nxt.sy1 = raw_pins;
    q_nxt.sy2 = q_r.sy1;
    q_nxt.sy3 = q_r.sy2;
    q_nxt.bus1 = io_bus_in;
    q_nxt.bus2 = q_r.bus1;
    // Read data stands one cycle only, then returns to zero
    q_nxt.rdata = pibs_pkg::RST_DATA;

    // Test entry only from self-test mode; otherwise the jumper means ROM test
    if (jumper_edge) begin
      if (q_r.sy2[pibs_pkg::SY_STMODE]) begin
        q_nxt.armed = 1'b1;
      end else begin
        q_nxt.rom_test = 1'b1;
      end
    end

    if (reg_wr_in) begin
      case (reg_addr_in)
        pibs_pkg::OFS_SELECT: begin
          q_nxt.sel = reg_wdata_in[3:0];
        end
        pibs_pkg::OFS_OUT_DATA: begin
          if (q_r.st == pibs_pkg::PIBS_IDLE && !test_active) begin
            q_nxt.dout = reg_wdata_in;
            q_nxt.st = pibs_pkg::PIBS_OUT;
            q_nxt.cnt = STROBE_LAST;
          end
        end
        pibs_pkg::OFS_IN_DATA: begin
          if (q_r.st == pibs_pkg::PIBS_IDLE && !test_active) begin
            q_nxt.st = pibs_pkg::PIBS_IN;
            q_nxt.cnt = STROBE_LAST;
          end
        end
        pibs_pkg::OFS_CONTROL: begin
          q_nxt.ctl_one = reg_wdata_in[pibs_pkg::CTL_LINE_ONE_BIT];
          q_nxt.ctl_two = reg_wdata_in[pibs_pkg::CTL_LINE_TWO_BIT];
          q_nxt.test_run = reg_wdata_in[pibs_pkg::CTL_TEST_RUN_BIT];
        end
        pibs_pkg::OFS_TEST_NUM: begin
          q_nxt.tnum = reg_wdata_in[5:0];
        end
        default: begin
        end
      endcase
    end

    if (reg_rd_in) begin
      case (reg_addr_in)
        pibs_pkg::OFS_SELECT: q_nxt.rdata = {12'h000, q_r.sel};
        pibs_pkg::OFS_OUT_DATA: q_nxt.rdata = q_r.dout;
        pibs_pkg::OFS_IN_DATA: q_nxt.rdata = q_r.din;
        pibs_pkg::OFS_CONTROL: q_nxt.rdata = {13'h0000, q_r.test_run, q_r.ctl_two, q_r.ctl_one};
        pibs_pkg::OFS_TEST_NUM: q_nxt.rdata = {10'h000, q_r.tnum};
        pibs_pkg::OFS_STATUS: begin
          q_nxt.rdata[pibs_pkg::ST_BUSY_BIT] = (q_r.st != pibs_pkg::PIBS_IDLE);
          q_nxt.rdata[pibs_pkg::ST_TEST_BIT] = (q_r.st == pibs_pkg::PIBS_TEST);
          q_nxt.rdata[pibs_pkg::ST_ROM_BIT] = q_r.rom_test;
          q_nxt.rdata[pibs_pkg::ST_FLAG_BIT] = act[pibs_pkg::SY_FLAG];
          q_nxt.rdata[pibs_pkg::ST_STATE_BIT] = act[pibs_pkg::SY_STATE];
          q_nxt.rdata[pibs_pkg::ST_IRH_BIT] = act[pibs_pkg::SY_IRH];
          q_nxt.rdata[pibs_pkg::ST_IRL_BIT] = act[pibs_pkg::SY_IRL];
          q_nxt.rdata[pibs_pkg::ST_XFER_BIT] = act[pibs_pkg::SY_XFER];
          q_nxt.rdata[pibs_pkg::ST_ARMED_BIT] = q_r.armed;
        end
        default: q_nxt.rdata = pibs_pkg::RST_DATA;
      endcase
    end

    case (q_r.st)
      pibs_pkg::PIBS_IDLE: begin
        if (test_active) begin
          q_nxt.st = pibs_pkg::PIBS_TEST;
          q_nxt.cnt = 8'h00;
        end
      end
      pibs_pkg::PIBS_OUT: begin
        if (q_r.cnt == 8'h00) begin
          q_nxt.st = pibs_pkg::PIBS_IDLE;
        end else begin
          q_nxt.cnt = q_r.cnt - 8'h01;
        end
      end
      pibs_pkg::PIBS_IN: begin
        if (q_r.cnt == 8'h00) begin
          // Sample two stages late, still inside the strobe window
          q_nxt.din = q_r.bus2;
          q_nxt.st = pibs_pkg::PIBS_IDLE;
        end else begin
          q_nxt.cnt = q_r.cnt - 8'h01;
        end
      end
      pibs_pkg::PIBS_TEST: begin
        // Left only by reset, so a running test cannot be stopped by software
        if (q_r.cnt == PERIOD_LAST) begin
          q_nxt.cnt = 8'h00;
          q_nxt.pat = q_r.pat + 16'h0001;
        end else begin
          q_nxt.cnt = q_r.cnt + 8'h01;
        end
      end
      default: begin
        q_nxt.st = pibs_pkg::PIBS_IDLE;
      end
    endcase

    // One decoded index drives at most one strobe, so buffers never fight
    q_nxt.os_n = pibs_pkg::RST_STROBES_N;
    q_nxt.is_n = pibs_pkg::RST_STROBES_N;
    q_nxt.bus_oe = 1'b0;
    // Next-cycle data, so the first strobe cycle already carries the new word
    q_nxt.bus_drv = q_nxt.dout;
    q_nxt.line_one = q_r.ctl_one;
    q_nxt.line_two = q_r.ctl_two;
    case (q_nxt.st)
      pibs_pkg::PIBS_OUT: begin
        // Line 0 trigger, 6 instrument bus, 11 cal, 12 graphics, 13 LO, 14 filter
        q_nxt.os_n[q_nxt.sel] = 1'b0;
        q_nxt.bus_oe = 1'b1;
      end
      pibs_pkg::PIBS_IN: begin
        // Lines 0-4 panel, 6 instrument bus, 8/11/12 counts, 13 overload, 15 filter
        q_nxt.is_n[q_nxt.sel] = 1'b0;
      end
      pibs_pkg::PIBS_TEST: begin
        q_nxt.bus_drv = q_nxt.pat;
        q_nxt.line_one = q_nxt.pat[0];
        q_nxt.line_two = q_nxt.pat[1];
        // Input-line tests release the bus so the selected board can drive it
        q_nxt.bus_oe = ~q_r.tnum[pibs_pkg::TNUM_DIR_BIT];
        if (q_nxt.cnt < STROBE_LEN_C && !test_line[4]) begin
          if (q_r.tnum[pibs_pkg::TNUM_DIR_BIT]) begin
            q_nxt.is_n[test_line[3:0]] = 1'b0;
          end else begin
            q_nxt.os_n[test_line[3:0]] = 1'b0;
          end
        end
      end
      default: begin
      end
    endcase

    // High priority follows the transfer request or the filter request level
    q_nxt.iph_n = ~(act[pibs_pkg::SY_XFER] | act[pibs_pkg::SY_IRH]);
    // Low priority: one pulse per record plus one per knob step
    if (xfer_edge || knob_edge) begin
      q_nxt.ipl_cnt = pibs_pkg::LOW_PULSE_CYCLES;
    end else if (q_r.ipl_cnt != 8'h00) begin
      q_nxt.ipl_cnt = q_r.ipl_cnt - 8'h01;
    end
    q_nxt.ipl_n = (q_nxt.ipl_cnt == 8'h00);
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_r <= '{
        st: pibs_pkg::PIBS_IDLE,
        sel: 4'h0,
        dout: pibs_pkg::RST_DATA,
        din: pibs_pkg::RST_DATA,
        ctl_one: 1'b0,
        ctl_two: 1'b0,
        test_run: 1'b0,
        tnum: pibs_pkg::RST_TNUM,
        cnt: 8'h00,
        pat: pibs_pkg::RST_DATA,
        armed: 1'b0,
        rom_test: 1'b0,
        rdata: pibs_pkg::RST_DATA,
        sy1: pibs_pkg::RST_SYNC,
        sy2: pibs_pkg::RST_SYNC,
        sy3: pibs_pkg::RST_SYNC,
        bus1: pibs_pkg::RST_DATA,
        bus2: pibs_pkg::RST_DATA,
        os_n: pibs_pkg::RST_STROBES_N,
        is_n: pibs_pkg::RST_STROBES_N,
        bus_drv: pibs_pkg::RST_DATA,
        bus_oe: 1'b0,
        line_one: 1'b0,
        line_two: 1'b0,
        iph_n: 1'b1,
        ipl_n: 1'b1,
        ipl_cnt: 8'h00
      };
    end else begin
      q_r <= q_nxt;
    end
  end

  assign reg_rdata_out = q_r.rdata;
  assign output_select_strobe_n_out = q_r.os_n;
  assign input_select_strobe_n_out = q_r.is_n;
  assign io_bus_out = q_r.bus_drv;
  assign io_bus_oe_out = q_r.bus_oe;
  assign control_line_one_out = q_r.line_one;
  assign control_line_two_out = q_r.line_two;
  assign high_prio_interrupt_n_out = q_r.iph_n;
  assign low_prio_interrupt_n_out = q_r.ipl_n;
  assign rom_self_test_start_out = q_r.rom_test;

endmodule
`default_nettype wire

// File: src/pibs_pkg.sv
// Constants, register map and state codes for the processor I/O bus select block.
// Assumes a single 100 MHz clock domain and a plain strobe register port.
`default_nettype none
package pibs_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned LINES = 16;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned SYNC_W = 7;

  // Register offsets
  localparam logic [3:0] OFS_SELECT = 4'h0;
  localparam logic [3:0] OFS_OUT_DATA = 4'h1;
  localparam logic [3:0] OFS_IN_DATA = 4'h2;
  localparam logic [3:0] OFS_CONTROL = 4'h3;
  localparam logic [3:0] OFS_TEST_NUM = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h5;

  // Field positions
  localparam int unsigned CTL_LINE_ONE_BIT = 0;
  localparam int unsigned CTL_LINE_TWO_BIT = 1;
  localparam int unsigned CTL_TEST_RUN_BIT = 2;
  localparam int unsigned TNUM_DIR_BIT = 5;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_TEST_BIT = 1;
  localparam int unsigned ST_ROM_BIT = 2;
  localparam int unsigned ST_FLAG_BIT = 3;
  localparam int unsigned ST_STATE_BIT = 4;
  localparam int unsigned ST_IRH_BIT = 5;
  localparam int unsigned ST_IRL_BIT = 6;
  localparam int unsigned ST_XFER_BIT = 7;
  localparam int unsigned ST_ARMED_BIT = 8;

  // Synchroniser bit positions
  localparam int unsigned SY_IRH = 0;
  localparam int unsigned SY_IRL = 1;
  localparam int unsigned SY_XFER = 2;
  localparam int unsigned SY_FLAG = 3;
  localparam int unsigned SY_STATE = 4;
  localparam int unsigned SY_JUMPER = 5;
  localparam int unsigned SY_STMODE = 6;

  // Cycle counts
  localparam logic [7:0] STROBE_CYCLES = 8'h04;
  localparam logic [7:0] TEST_PERIOD_CYCLES = 8'h10;
  localparam logic [7:0] LOW_PULSE_CYCLES = 8'h08;

  // Test numbers, read as printed octal digits
  localparam logic [4:0] TNUM_FIRST_GAP = 5'h08;
  localparam logic [4:0] TNUM_HIGH_FIRST = 5'h0A;
  localparam logic [4:0] TNUM_LAST = 5'h11;
  localparam logic [4:0] TNUM_OCTAL_SKIP = 5'h02;

  // Reset values
  localparam logic [15:0] RST_DATA = 16'h0000;
  localparam logic [15:0] RST_STROBES_N = 16'hFFFF;
  localparam logic [5:0] RST_TNUM = 6'h00;
  localparam logic [6:0] RST_SYNC = 7'h7F;

  typedef enum logic [1:0] {
    PIBS_IDLE = 2'b00,
    PIBS_OUT = 2'b01,
    PIBS_IN = 2'b10,
    PIBS_TEST = 2'b11
  } pibs_state_t;
endpackage
`default_nettype wire

// File: verif/pibs_periph_model.sv
// Peripheral boards on the shared bus, seen from the pins.
// Assumes one strobe per board line; released bus toggles every cycle.
`default_nettype none
module pibs_periph_model (
  input wire logic clk_in,
  input wire logic [15:0] is_n_in,
  input wire logic [15:0] os_n_in,
  input wire logic [15:0] drv_in,
  input wire logic oe_in,
  output logic [15:0] bus_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] latched [16];
  logic [15:0] idle_r = 16'h0000;
  logic [3:0] line;
  logic any_in;
  always_comb begin
    line = 4'h0;
    any_in = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (!is_n_in[i]) begin
        line = i[3:0];
        any_in = 1'b1;
      end
    end
  end
  // Buffers drive only while gated; else the wire shows no stale value
  assign bus_out = any_in ? {12'hA50, line} : (oe_in ? drv_in : idle_r);
  always @(posedge clk_in) begin
    idle_r <= ~bus_out;
    for (int i = 0; i < 16; i++) begin
      if (!os_n_in[i]) begin
        latched[i] <= bus_out;
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/pibs_io_bus_select_sva.sv
// Timing checks on the select strobes, bus drive and interrupt lines.
// Assumes the default strobe length of four cycles.
`default_nettype none
module pibs_io_bus_select_chk (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [pibs_pkg::LINES-1:0] output_select_strobe_n_out,
  input wire logic [pibs_pkg::LINES-1:0] input_select_strobe_n_out,
  input wire logic io_bus_oe_out,
  input wire logic filter_transfer_request_n_in,
  input wire logic knob_interrupt_request_n_in,
  input wire logic test_jumper_shorted_in,
  input wire logic self_test_mode_in,
  input wire logic high_prio_interrupt_n_out,
  input wire logic low_prio_interrupt_n_out,
  input wire logic rom_self_test_start_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  chk_in_single: assert property ($countones(~input_select_strobe_n_out) <= 1)
    else $error("more than one input strobe low");
  chk_out_len: assert property ($fell(&output_select_strobe_n_out) |->
    (!(&output_select_strobe_n_out))[*4] ##1 (&output_select_strobe_n_out))
    else $error("output strobe length wrong");
  chk_out_drives: assert property (!(&output_select_strobe_n_out) |-> io_bus_oe_out)
    else $error("output strobe without bus drive");
  chk_in_listens: assert property (!(&input_select_strobe_n_out) |-> !io_bus_oe_out)
    else $error("bus driven during input strobe");
  chk_high_prio: assert property ((!filter_transfer_request_n_in)[*3] |=>
    !high_prio_interrupt_n_out)
    else $error("high priority interrupt missing");
  chk_low_pulse: assert property ($fell(low_prio_interrupt_n_out) |->
    (!low_prio_interrupt_n_out)[*8])
    else $error("low priority pulse too short");
  chk_low_cause: assert property ($fell(knob_interrupt_request_n_in) |->
    ##[1:5] !low_prio_interrupt_n_out)
    else $error("knob request not passed on");
  chk_rom_start: assert property ($rose(test_jumper_shorted_in) && !self_test_mode_in |->
    ##[1:6] rom_self_test_start_out)
    else $error("rom self test not started");
  cover property ($fell(&output_select_strobe_n_out));
  cover property ($fell(&input_select_strobe_n_out));
  cover property ($fell(low_prio_interrupt_n_out));
endmodule
bind pibs_io_bus_select pibs_io_bus_select_chk i_chk (.ref_clk_in, .rst_in,
  .output_select_strobe_n_out, .input_select_strobe_n_out, .io_bus_oe_out,
  .filter_transfer_request_n_in, .knob_interrupt_request_n_in, .test_jumper_shorted_in,
  .self_test_mode_in, .high_prio_interrupt_n_out, .low_prio_interrupt_n_out,
  .rom_self_test_start_out);
`default_nettype wire

// File: verif/test_processor_io_bus_select.sv
// Testbench: register tasks drive the block, a peripheral model answers.
// Assumes default strobe length and test period.
`default_nettype none
module test_processor_io_bus_select;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata, os_n, is_n, bus_in, bus_out;
  logic oe, ctl1, ctl2, hp_n, lp_n, rom;
  logic irh_n = 1'b1;
  logic irl_n = 1'b1;
  logic xfer_n = 1'b1;
  logic flag_n = 1'b1;
  logic state_n = 1'b1;
  logic jumper = 1'b0;
  logic stmode = 1'b0;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  int ol[6] = '{0, 6, 11, 12, 13, 14};
  int il[11] = '{0, 1, 2, 3, 4, 6, 8, 11, 12, 13, 15};
  pibs_io_bus_select i_pibs_io_bus_select (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .output_select_strobe_n_out(os_n),
    .input_select_strobe_n_out(is_n), .io_bus_in(bus_in), .io_bus_out(bus_out),
    .io_bus_oe_out(oe), .control_line_one_out(ctl1), .control_line_two_out(ctl2),
    .filter_interrupt_request_n_in(irh_n), .knob_interrupt_request_n_in(irl_n),
    .filter_transfer_request_n_in(xfer_n), .instrument_bus_flag_n_in(flag_n),
    .instrument_bus_state_line_n_in(state_n), .test_jumper_shorted_in(jumper),
    .self_test_mode_in(stmode), .high_prio_interrupt_n_out(hp_n),
    .low_prio_interrupt_n_out(lp_n), .rom_self_test_start_out(rom));
  pibs_periph_model i_pibs_periph_model (.clk_in(ref_clk_in), .is_n_in(is_n),
    .os_n_in(os_n), .drv_in(bus_out), .oe_in(oe), .bus_out(bus_in));
  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Ceiling well above the roughly 500 cycles the tests need
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input string what, input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask
  task automatic count_low(input logic [15:0] pat, input logic use_in);
    n = 0;
    repeat (32) begin
      tick(1);
      if ((use_in ? is_n : os_n) === pat) n++;
    end
  endtask
  task automatic do_reset();
    @(posedge ref_clk_in);
    rst_in <= 1'b1;
    jumper <= 1'b0;
    stmode <= 1'b0;
    tick(2);
    @(posedge ref_clk_in);
    rst_in <= 1'b0;
    tick(4);
  endtask
  initial begin
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    tick(2);
    chk("idle strobes", 16'hFFFF, os_n & is_n);
    chk("idle lines", 16'h0003, {14'h0000, hp_n, lp_n});
    $display("test reset done");
    foreach (ol[i]) begin
      wr_reg(pibs_pkg::OFS_SELECT, 16'(ol[i]));
      wr_reg(pibs_pkg::OFS_OUT_DATA, 16'h3C00 + 16'(ol[i]));
      chk("output strobe", ~(16'h0001 << ol[i]), os_n);
      tick(6);
      chk("latched", 16'h3C00 + 16'(ol[i]), i_pibs_periph_model.latched[ol[i]]);
    end
    $display("test output strobes done");
    foreach (il[i]) begin
      wr_reg(pibs_pkg::OFS_SELECT, 16'(il[i]));
      wr_reg(pibs_pkg::OFS_IN_DATA, 16'h0000);
      chk("input strobe", ~(16'h0001 << il[i]), is_n);
      wr_reg(pibs_pkg::OFS_OUT_DATA, 16'h5555);
      chk("refused output", 16'hFFFF, os_n);
      tick(4);
      rd_reg("captured", pibs_pkg::OFS_IN_DATA, 16'hA500 | 16'(il[i]));
    end
    $display("test input strobes done");
    for (int v = 3; v >= 0; v--) begin
      wr_reg(pibs_pkg::OFS_CONTROL, 16'(v));
      tick(1);
      chk("control lines", 16'(v), {14'h0000, ctl2, ctl1});
    end
    rd_reg("unmapped", 4'hF, 16'h0000);
    $display("test control done");
    @(posedge ref_clk_in) xfer_n <= 1'b0;
    tick(5);
    chk("interrupts", 16'h0000, {14'h0000, hp_n, lp_n});
    @(posedge ref_clk_in) xfer_n <= 1'b1;
    tick(14);
    chk("interrupts idle", 16'h0003, {14'h0000, hp_n, lp_n});
    @(posedge ref_clk_in) irh_n <= 1'b0;
    tick(5);
    chk("high prio", 16'h0000, {15'h0000, hp_n});
    @(posedge ref_clk_in) irh_n <= 1'b1;
    repeat (2) begin
      @(posedge ref_clk_in) irl_n <= 1'b0;
      tick(2);
      @(posedge ref_clk_in) irl_n <= 1'b1;
      tick(3);
      chk("low prio pulse", 16'h0000, {15'h0000, lp_n});
      tick(12);
      chk("low prio idle", 16'h0001, {15'h0000, lp_n});
    end
    @(posedge ref_clk_in) flag_n <= 1'b0;
    tick(4);
    rd_reg("status flag", pibs_pkg::OFS_STATUS, 16'h0008);
    @(posedge ref_clk_in) {flag_n, state_n} <= 2'b10;
    tick(4);
    rd_reg("status state", pibs_pkg::OFS_STATUS, 16'h0010);
    @(posedge ref_clk_in) state_n <= 1'b1;
    $display("test interrupts done");
    @(posedge ref_clk_in) jumper <= 1'b1;
    tick(8);
    rd_reg("rom start", pibs_pkg::OFS_STATUS, 16'h0004);
    chk("rom pin", 16'h0001, {15'h0000, rom});
    do_reset();
    chk("rom cleared", 16'h0000, {15'h0000, rom});
    @(posedge ref_clk_in) stmode <= 1'b1;
    tick(4);
    @(posedge ref_clk_in) jumper <= 1'b1;
    tick(8);
    chk("armed not rom", 16'h0000, {15'h0000, rom});
    rd_reg("armed", pibs_pkg::OFS_STATUS, 16'h0100);
    wr_reg(pibs_pkg::OFS_TEST_NUM, 16'h000F);
    wr_reg(pibs_pkg::OFS_CONTROL, 16'h0004);
    tick(4);
    count_low(~16'h2000, 1'b0);
    chk("test strobe cycles", 16'h0008, 16'(n));
    chk("test drives bus", 16'h0001, {15'h0000, oe});
    chk("test pattern", 16'h0002, bus_out);
    chk("test control lines", 16'h0002, {14'h0000, ctl2, ctl1});
    do_reset();
    wr_reg(pibs_pkg::OFS_CONTROL, 16'h0004);
    tick(4);
    count_low(16'hFFFF, 1'b0);
    chk("test stopped", 16'h0020, 16'(n));
    wr_reg(pibs_pkg::OFS_TEST_NUM, 16'h0024);
    @(posedge ref_clk_in) stmode <= 1'b1;
    tick(4);
    @(posedge ref_clk_in) jumper <= 1'b1;
    tick(8);
    count_low(~16'h0010, 1'b1);
    chk("input test strobe cycles", 16'h0008, 16'(n));
    chk("input test releases bus", 16'h0000, {15'h0000, oe});
    $display("test bus test done");
    final_report();
  end
endmodule
`default_nettype wire
